// file: hdl/scsp_regs.svh
// Register map, field positions, reset values for the serial control port.
// Assumes byte addressing on a 32-bit Avalon-MM slave, one register a word.
`ifndef SCSP_REGS_SVH
`define SCSP_REGS_SVH

// ==========================================================================
// Offsets
`define OFS_BIT_RATE 5'h00
`define OFS_CONTROL 5'h04
`define OFS_STATUS 5'h08
`define OFS_PIN_PORT 5'h0c
`define OFS_TX_HOLD 5'h10
`define OFS_RX_HOLD 5'h14

// ==========================================================================
// Control fields
`define CTL_TX_EMPTY_IE 7
`define CTL_RX_FULL_IE 6
`define CTL_TX_ON 5
`define CTL_RX_ON 4
`define CTL_MP_IE 3
`define CTL_TX_DONE_IE 2
`define CTL_CLK_EXT 1
`define CTL_CLK_OUT 0

// ==========================================================================
// Status fields
`define ST_TX_EMPTY 7
`define ST_RX_FULL 6
`define ST_OVERRUN 5
`define ST_FRAME 4
`define ST_PARITY 3
`define ST_TX_DONE 2
`define ST_RX_MP 1
`define ST_TX_MP 0

// ==========================================================================
// Pin port fields
`define PP_ERR_ONLY 7
`define PP_CLK_DIR 3
`define PP_CLK_VAL 2
`define PP_BRK_DIR 1
`define PP_BRK_VAL 0

// ==========================================================================
// Reset values
`define CONTROL_RESET 8'h00
`define STATUS_RESET 8'h84
`define DIVISOR_RESET 8'hff
`define TX_HOLD_RESET 8'hff
`define RX_HOLD_RESET 8'h00

// ==========================================================================
// Timing
`define X16_SAMPLE_PULSE 4'h7
`define X16_HALF_BIT 3'h7
`define SYNC_HALF_BIT 1'h1

`endif

// file: hdl/scsp_pkg.sv
// Types shared by the serial control port and its baud generator.
// Assumes the frame sequencer reports events on the same clock.
package scsp_pkg;

  // ========================================================================
  // State machines
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_st_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} rx_st_t;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic sync_mode;
    logic parity_on;
    logic multiproc_on;
    logic prescale_sel_hi;
    logic prescale_sel_lo;
  } frame_cfg_t;

  typedef struct packed {
    logic load;
    logic last_bit;
    logic serial;
  } tx_event_t;

  typedef struct packed {
    logic done;
    logic frame_err;
    logic parity_err;
    logic [7:0] data;
  } rx_event_t;

endpackage

// file: hdl/scsp_baud_gen.sv
// Baud generator: prescaler, divisor counter, 16x tick and bit clock.
// Assumes a divisor and prescale selection held stable by software.
`timescale 1ns/1ps
`include "scsp_regs.svh"
module scsp_baud_gen
  import scsp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_prescale,
  input wire logic [7:0] i_divisor,
  input wire logic i_sync_mode,
  output logic o_x16_tick,
  output logic o_bit_clk
);

  // ========================================================================
  // Prescaler and divisor
  function automatic logic [5:0] pre_last(input logic [1:0] sel);
    case (sel)
      2'h0: pre_last = 6'h00;
      2'h1: pre_last = 6'h03;
      2'h2: pre_last = 6'h0f;
      default: pre_last = 6'h3f;
    endcase
  endfunction

  logic [5:0] pre_r;
  logic [7:0] div_r;
  logic half_r;
  logic [2:0] phase_r;
  logic bit_clk_r;
  wire pre_wrap = (pre_r >= pre_last(i_prescale));
  wire base_tick = pre_wrap && (div_r >= i_divisor);
  wire x16_tick = base_tick && half_r;
  wire half_bit = i_sync_mode ? (phase_r[0] == `SYNC_HALF_BIT)
                              : (phase_r == `X16_HALF_BIT);
  wire phase_tick = i_sync_mode ? base_tick : x16_tick;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pre_r <= 6'h00;
      div_r <= 8'h00;
      half_r <= 1'b0;
      phase_r <= 3'h0;
      bit_clk_r <= 1'b1;
    end
    else
    begin
      pre_r <= pre_wrap ? 6'h00 : pre_r + 6'h01;
      if (pre_wrap)
        div_r <= (div_r >= i_divisor) ? 8'h00 : div_r + 8'h01;
      if (base_tick)
        half_r <= ~half_r;
      if (phase_tick)
        phase_r <= half_bit ? 3'h0 : phase_r + 3'h1;
      if (phase_tick && half_bit)
        bit_clk_r <= ~bit_clk_r;
    end
  end

  assign o_x16_tick = x16_tick;
  assign o_bit_clk = bit_clk_r;

endmodule

// file: hdl/serial_control_status_port.sv
// Control, status, pin port and bit rate registers of a serial port.
// Assumes a frame sequencer on i_clk and pins from outside the domain.
//
// Functional notes
// - Control clears on reset and standby
// - Transmit-empty enable gates transmit-empty request
// - Receive-full enable gates full and error requests
// - Transmit starts after data written, flag cleared
// - Receiver off keeps receive flags unchanged
// - Reception starts on start bit or clock
// - Multiprocessor enable only in async multiprocessor
// - Transmit-done enable gates transmit-done request
// - External clock input; clock output bit-rate
// - Status becomes 84 hex on reset, standby
// - Flags clear by zero after reading one
// - Transmit-empty sets when holding data moves
// - Receive-full sets; second byte causes overrun
// - Framing error sets flag, halts reception
// - Parity error stores byte, halts reception
// - Transmit-done sets at end, holding empty
// - Transmit multiprocessor bit is single buffered
// - Error-only bit suppresses receive-full request
// - Clock port drives and reads clock pin
// - Break port drives transmit, reads receive
// - Pin port survives standby; reserved read zero
// - Divisor resets FF, sets bit rate
// - Prescale selects divide by 1,4,16,64
// - Async receive samples on eighth 16x pulse
`timescale 1ns/1ps
`include "scsp_regs.svh"
module serial_control_status_port
  import scsp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_standby,
  input wire logic i_module_standby,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire frame_cfg_t i_cfg,
  input wire tx_event_t i_tx,
  input wire rx_event_t i_rx,
  output logic [7:0] o_tx_data,
  output logic o_tx_pending,
  output logic o_tx_multiproc_bit,
  output logic o_rx_enable,
  output logic o_rx_start,
  output logic o_rx_sample,
  output logic o_multiproc_irq_en,
  output logic o_tx_empty_irq,
  output logic o_rx_full_irq,
  output logic o_rx_fault_irq,
  output logic o_tx_done_irq,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe
);

  // ========================================================================
  // Helpers
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction

  // ========================================================================
  // State
  bus_st_t bus_st_r;
  rx_st_t rx_st_r;
  logic [31:0] readdata_r;
  logic [7:0] divisor_r;
  logic [7:0] ctrl_r;
  logic [7:0] tx_hold_r;
  logic [7:0] rx_hold_r;
  logic tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, fer_r, per_r, tx_done_flag_r, tx_multiproc_bit_r;
  logic [4:0] armed_r;
  logic eio_r, ckdir_r, ckval_r, bkdir_r, bkval_r;
  logic rxd_m_r, rxd_s_r, rxd_d_r;
  logic sck_m_r, sck_s_r, sck_d_r;
  logic [3:0] x16_cnt_r;
  logic txd_r, sck_r, sck_oe_r, bit_clk_d_r;
  logic x16_gen, bit_clk;

  // ========================================================================
  // Bus decode
  wire req = i_avs_read | i_avs_write;
  wire acc = req && (bus_st_r == BUS_ACK);
  wire wr_acc = acc && i_avs_write && i_avs_byteenable[0];
  wire rd_acc = acc && i_avs_read;
  wire [7:0] wd = i_avs_writedata[7:0];
  wire sel_brr = (i_avs_address == `OFS_BIT_RATE);
  wire sel_ctl = (i_avs_address == `OFS_CONTROL);
  wire sel_st = (i_avs_address == `OFS_STATUS);
  wire sel_pp = (i_avs_address == `OFS_PIN_PORT);
  wire sel_tdr = (i_avs_address == `OFS_TX_HOLD);
  wire sel_rdr = (i_avs_address == `OFS_RX_HOLD);
  wire wr_st = wr_acc && sel_st;
  wire clr = i_rst | i_standby | i_module_standby;
  wire [7:0] status_rst = `STATUS_RESET;

  // ========================================================================
  // Control decode
  wire tx_on = ctrl_r[`CTL_TX_ON];
  wire rx_on = ctrl_r[`CTL_RX_ON];
  wire clk_ext = ctrl_r[`CTL_CLK_EXT];
  wire clk_out = ctrl_r[`CTL_CLK_OUT];
  wire sync_mode = i_cfg.sync_mode;
  wire [7:0] status = {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, fer_r, per_r, tx_done_flag_r,
                       1'b0, tx_multiproc_bit_r};
  wire [4:0] flags = {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, fer_r, per_r};
  wire [7:0] pin_port = {eio_r, 3'h0, ckdir_r, sck_s_r, bkdir_r, rxd_s_r};
  wire [7:0] rd_mux = sel_brr ? divisor_r :
                      sel_ctl ? ctrl_r :
                      sel_st ? status :
                      sel_pp ? pin_port :
                      sel_tdr ? tx_hold_r :
                      sel_rdr ? rx_hold_r : 8'h00;

  // ========================================================================
  // Flag events
  wire [4:0] clr_req = (wr_st ? ~{wd[`ST_TX_EMPTY], wd[`ST_RX_FULL],
                        wd[`ST_OVERRUN], wd[`ST_FRAME], wd[`ST_PARITY]}
                        : 5'h00) & armed_r;
  wire tx_empty_flag_set = i_tx.load | ~tx_on;
  wire tx_done_flag_set = i_tx.last_bit & tx_empty_flag_r;
  wire rx_new = i_rx.done & ~rx_full_flag_r;
  wire ovr_set = i_rx.done & rx_full_flag_r;
  wire fer_set = rx_new & i_rx.frame_err;
  wire par_chk = ~sync_mode & i_cfg.parity_on & ~i_cfg.multiproc_on;
  wire per_set = rx_new & ~i_rx.frame_err & i_rx.parity_err & par_chk;
  wire rx_full_flag_set = rx_new & ~i_rx.frame_err & ~per_set;
  wire rx_store = rx_new & ~i_rx.frame_err;

  // ========================================================================
  // Pin edges and sample timing
  wire rx_run = rx_on & ~(overrun_flag_r | fer_r | per_r);
  wire rx_fall = rxd_d_r & ~rxd_s_r;
  wire sck_rise = sck_s_r & ~sck_d_r;
  wire x16_tick = clk_ext ? sck_rise : x16_gen;
  wire sync_tick = clk_ext ? sck_rise : (bit_clk & ~bit_clk_d_r);
  wire start_async = rx_run & ~sync_mode & rx_fall;
  wire start_sync = rx_run & sync_mode & sync_tick;
  wire rx_idle = (rx_st_r == RX_IDLE);
  wire sck_serial = ~clk_ext & (sync_mode | clk_out);

  // ========================================================================
  // Bus handshake
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bus_st_r <= BUS_IDLE;
      readdata_r <= 32'h0000_0000;
    end
    else
    begin
      case (bus_st_r)
        BUS_IDLE:
        begin
          if (req)
          begin
            bus_st_r <= BUS_ACK;
            readdata_r <= {24'h00_0000, rd_mux};
          end
        end
        BUS_ACK: bus_st_r <= BUS_IDLE;
        default: bus_st_r <= BUS_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Registers cleared by reset and standby
  always_ff @(posedge i_clk)
  begin
    if (clr)
    begin
      ctrl_r <= `CONTROL_RESET;
      divisor_r <= `DIVISOR_RESET;
      tx_hold_r <= `TX_HOLD_RESET;
      rx_hold_r <= `RX_HOLD_RESET;
      tx_empty_flag_r <= status_rst[`ST_TX_EMPTY];
      tx_done_flag_r <= status_rst[`ST_TX_DONE];
      {rx_full_flag_r, overrun_flag_r, fer_r, per_r, tx_multiproc_bit_r} <= 5'h00;
      armed_r <= 5'h00;
    end
    else
    begin
      if (wr_acc && sel_ctl)
        ctrl_r <= wd;
      if (wr_acc && sel_brr)
        divisor_r <= wd;
      if (wr_acc && sel_tdr)
        tx_hold_r <= wd;
      if (rx_store)
        rx_hold_r <= i_rx.data;
      if (wr_st)
        tx_multiproc_bit_r <= wd[`ST_TX_MP];
      tx_empty_flag_r <= flag_next(tx_empty_flag_r, tx_empty_flag_set, clr_req[4]);
      rx_full_flag_r <= flag_next(rx_full_flag_r, rx_full_flag_set, clr_req[3]);
      overrun_flag_r <= flag_next(overrun_flag_r, ovr_set, clr_req[2]);
      fer_r <= flag_next(fer_r, fer_set, clr_req[1]);
      per_r <= flag_next(per_r, per_set, clr_req[0]);
      tx_done_flag_r <= flag_next(tx_done_flag_r, tx_done_flag_set, clr_req[4] & ~tx_empty_flag_set);
      armed_r <= (armed_r & flags & ~clr_req) |
                 (rd_acc && sel_st ? {readdata_r[7:3]} & flags : 5'h00);
    end
  end

  // ========================================================================
  // Pin port, kept through standby
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      {eio_r, ckdir_r, ckval_r, bkdir_r, bkval_r} <= 5'h00;
    end
    else if (wr_acc && sel_pp)
    begin
      eio_r <= wd[`PP_ERR_ONLY];
      ckdir_r <= wd[`PP_CLK_DIR];
      ckval_r <= wd[`PP_CLK_VAL];
      bkdir_r <= wd[`PP_BRK_DIR];
      bkval_r <= wd[`PP_BRK_VAL];
    end
  end

  // ========================================================================
  // Pin synchronisers and receive sampling
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      {rxd_m_r, rxd_s_r, rxd_d_r} <= 3'h7;
      {sck_m_r, sck_s_r, sck_d_r} <= 3'h7;
      rx_st_r <= RX_IDLE;
      x16_cnt_r <= 4'h0;
      bit_clk_d_r <= 1'b1;
    end
    else
    begin
      rxd_m_r <= i_rxd;
      rxd_s_r <= rxd_m_r;
      rxd_d_r <= rxd_s_r;
      sck_m_r <= i_sck;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      bit_clk_d_r <= bit_clk;
      case (rx_st_r)
        RX_IDLE:
        begin
          x16_cnt_r <= 4'h0;
          if (start_async)
            rx_st_r <= RX_BUSY;
        end
        RX_BUSY:
        begin
          if (i_rx.done || !rx_run)
            rx_st_r <= RX_IDLE;
          if (x16_tick)
            x16_cnt_r <= x16_cnt_r + 4'h1;
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Pin drivers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      txd_r <= 1'b1;
      sck_r <= 1'b1;
      sck_oe_r <= 1'b0;
    end
    else
    begin
      txd_r <= tx_on ? i_tx.serial : (bkdir_r ? bkval_r : 1'b1);
      sck_r <= sck_serial ? bit_clk : ckval_r;
      sck_oe_r <= sck_serial | (ckdir_r & ~clk_ext);
    end
  end

  scsp_baud_gen u_baud (
    .i_clk(i_clk),
    .i_rst(clr),
    .i_prescale({i_cfg.prescale_sel_hi, i_cfg.prescale_sel_lo}),
    .i_divisor(divisor_r),
    .i_sync_mode(sync_mode),
    .o_x16_tick(x16_gen),
    .o_bit_clk(bit_clk)
  );

  // ========================================================================
  // Outputs
  assign o_avs_waitrequest = req && (bus_st_r == BUS_IDLE);
  assign o_avs_readdata = readdata_r;
  assign o_tx_data = tx_hold_r;
  assign o_tx_pending = tx_on & ~tx_empty_flag_r;
  assign o_tx_multiproc_bit = tx_multiproc_bit_r;
  assign o_rx_enable = rx_run;
  assign o_rx_start = rx_idle & (start_async | start_sync);
  assign o_rx_sample = ~rx_idle & x16_tick &
                       (x16_cnt_r == `X16_SAMPLE_PULSE);
  assign o_multiproc_irq_en = ctrl_r[`CTL_MP_IE] & ~sync_mode &
                              i_cfg.multiproc_on;
  assign o_tx_empty_irq = ctrl_r[`CTL_TX_EMPTY_IE] & tx_empty_flag_r;
  assign o_rx_full_irq = ctrl_r[`CTL_RX_FULL_IE] & rx_full_flag_r &
                         ~eio_r;
  assign o_rx_fault_irq = ctrl_r[`CTL_RX_FULL_IE] &
                          (overrun_flag_r | fer_r | per_r);
  assign o_tx_done_irq = ctrl_r[`CTL_TX_DONE_IE] & tx_done_flag_r;
  assign o_txd = txd_r;
  assign o_sck = sck_r;
  assign o_sck_oe = sck_oe_r;

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_status_standby: assert property (i_standby |=> status == `STATUS_RESET)
    else $error("status not 84 after standby");
  a_ctrl_standby: assert property (i_module_standby |=> ctrl_r == 8'h00)
    else $error("control not cleared");
  a_tx_empty_flag_on_load: assert property (i_tx.load |=> tx_empty_flag_r && o_tx_empty_irq
                                   == ctrl_r[`CTL_TX_EMPTY_IE])
    else $error("transmit empty not set");
  a_overrun_discard: assert property (ovr_set && !clr |=> overrun_flag_r &&
                                      $stable(rx_hold_r))
    else $error("overrun not handled");
  a_frame_no_full: assert property (fer_set && !clr |=> fer_r && !rx_full_flag_r
                                    ##0 !o_rx_enable)
    else $error("framing error handling");
  a_parity_store: assert property (per_set && !clr |=> per_r && !rx_full_flag_r &&
                                   rx_hold_r == $past(i_rx.data))
    else $error("parity error handling");
  a_clear_needs_read: assert property (wr_st && !wd[`ST_RX_FULL] &&
                                       !armed_r[3] && rx_full_flag_r && !clr
                                       |=> rx_full_flag_r)
    else $error("flag cleared without read");
  a_full_irq_gate: assert property (eio_r && rx_full_flag_r |-> !o_rx_full_irq)
    else $error("receive full not suppressed");
  a_tx_done_flag_set: assert property (tx_done_flag_set && !clr |=> tx_done_flag_r ##0
                               o_tx_done_irq == ctrl_r[`CTL_TX_DONE_IE])
    else $error("transmit done not set");
  a_break_drive: assert property (!tx_on && bkdir_r ##1 !tx_on && bkdir_r
                                  |=> o_txd == $past(bkval_r))
    else $error("break value not on line");
  a_rx_off_keep: assert property ($fell(rx_on) && !$past(wr_st) &&
                                  !$past(i_rx.done) && !$past(clr)
                                  |-> $stable(flags[3:0]))
    else $error("flags moved on receiver off");

endmodule

// file: tb/serial_peer.sv
// Far-side serial device: drives receive line and clock line levels.
// Assumes the bench sets the wanted levels; changes land on clock edges.
`timescale 1ns/1ps
module serial_peer
(
  input wire logic i_clk,
  input wire logic i_rxd_level,
  input wire logic i_sck_level,
  output logic o_rxd,
  output logic o_sck
);
  // ==========================================================================
  // Line drivers
  initial
  begin
    o_rxd = 1'b1;
    o_sck = 1'b1;
  end

  always @(posedge i_clk)
  begin
    o_rxd <= i_rxd_level;
    o_sck <= i_sck_level;
  end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the serial control, status and pin port block.
// Assumes the Avalon slave answers with waitrequest; frame events by bench.
`timescale 1ns/1ps
module testbench;
  import scsp_pkg::*;
  logic clk = 0, rst = 1, stby = 0, mstby = 0, rd_s = 0, wr_s = 0;
  logic [4:0] adr = '0;
  logic [31:0] wdat = '0, rdat;
  logic [3:0] be = 4'hf;
  frame_cfg_t cfg = '0;
  tx_event_t tx = '0;
  rx_event_t rx = '0;
  logic rxd_lv = 1, sck_lv = 1, peer_rxd, peer_sck, sck_w, seen_start = 0;
  logic wait_r, txd, sck_o, sck_oe, pend, tx_multiproc_bit, rx_en, rx_start, mp_ie;
  logic [7:0] txdat, q;
  logic irq_te, irq_rf, irq_er, irq_td, rx_samp;
  int fail_count = 0, num_checks = 0, cyc = 0, n_samp = 0;

  // ==========================================================================
  // Clock, pin wiring, instances
  always #20 clk = ~clk;
  assign sck_w = sck_oe ? sck_o : peer_sck;

  serial_peer serial_peer_inst (.i_clk(clk), .i_rxd_level(rxd_lv),
    .i_sck_level(sck_lv), .o_rxd(peer_rxd), .o_sck(peer_sck));

  serial_control_status_port serial_control_status_port_inst (
    .i_clk(clk), .i_rst(rst), .i_standby(stby), .i_module_standby(mstby),
    .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s),
    .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_r), .i_cfg(cfg), .i_tx(tx), .i_rx(rx),
    .o_tx_data(txdat), .o_tx_pending(pend), .o_tx_multiproc_bit(tx_multiproc_bit),
    .o_rx_enable(rx_en), .o_rx_start(rx_start), .o_rx_sample(rx_samp),
    .o_multiproc_irq_en(mp_ie), .o_tx_empty_irq(irq_te),
    .o_rx_full_irq(irq_rf), .o_rx_fault_irq(irq_er), .o_tx_done_irq(irq_td),
    .i_rxd(peer_rxd), .o_txd(txd), .i_sck(sck_w), .o_sck(sck_o),
    .o_sck_oe(sck_oe));

  // ==========================================================================
  // Checking, bus access, events
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rw(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wr_s <= w;
    rd_s <= ~w;
    wdat <= {24'h0, d};
    do
      @(posedge clk);
    while (wait_r !== 1'b0);
    q = rdat[7:0];
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    rw(1'b0, a, 8'h00);
    check(q & m, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic rx_ev(input logic fe, input logic pe, input logic [7:0] d);
    @(posedge clk);
    rx <= '{done: 1'b1, frame_err: fe, parity_err: pe, data: d};
    @(posedge clk);
    rx <= '0;
    idle(1);
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rx_start === 1'b1)
      seen_start <= 1'b1;
    if (rx_samp === 1'b1)
      n_samp <= n_samp + 1;
    if (cyc == 6000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(5'h00, 8'hff, 8'hff);
    rdc(5'h04, 8'hff, 8'h00);
    rdc(5'h08, 8'hff, 8'h84);
    rdc(5'h10, 8'hff, 8'hff);
    rdc(5'h14, 8'hff, 8'h00);
    rdc(5'h18, 8'hff, 8'h00);
    rw(1'b1, 5'h08, 8'h00);
    rdc(5'h08, 8'hff, 8'h84);
    rw(1'b1, 5'h04, 8'he4);
    check({irq_te, irq_td, pend}, 8'h06);
    rw(1'b1, 5'h10, 8'h3c);
    rw(1'b1, 5'h08, 8'h01);
    rdc(5'h08, 8'hff, 8'h01);
    check({pend, tx_multiproc_bit, irq_te}, 8'h06);
    check(txdat, 8'h3c);
    @(posedge clk);
    tx <= '{load: 1'b1, last_bit: 1'b0, serial: 1'b1};
    @(posedge clk);
    tx <= '{load: 1'b0, last_bit: 1'b1, serial: 1'b1};
    @(posedge clk);
    tx <= '{load: 1'b0, last_bit: 1'b0, serial: 1'b1};
    idle(1);
    check({irq_te, irq_td}, 8'h03);
    rdc(5'h08, 8'hff, 8'h85);
    rw(1'b1, 5'h04, 8'h52);
    rxd_lv <= 1'b0;
    idle(6);
    check({7'h0, seen_start}, 8'h01);
    repeat (7)
    begin
      sck_lv <= 1'b0;
      idle(2);
      sck_lv <= 1'b1;
      idle(2);
    end
    idle(3);
    check(n_samp[7:0], 8'h00);
    sck_lv <= 1'b0;
    idle(2);
    sck_lv <= 1'b1;
    idle(5);
    check(n_samp[7:0], 8'h01);
    rxd_lv <= 1'b1;
    rx_ev(1'b0, 1'b0, 8'h5a);
    check({irq_rf, irq_er}, 8'h02);
    rw(1'b1, 5'h08, 8'h00);
    rx_ev(1'b0, 1'b0, 8'h33);
    rdc(5'h08, 8'h78, 8'h60);
    rdc(5'h14, 8'hff, 8'h5a);
    check({irq_er, rx_en}, 8'h02);
    rw(1'b1, 5'h0c, 8'h80);
    check({irq_rf, irq_er}, 8'h01);
    rw(1'b1, 5'h04, 8'h40);
    rdc(5'h08, 8'h78, 8'h60);
    rw(1'b1, 5'h08, 8'h00);
    rdc(5'h08, 8'h78, 8'h00);
    rw(1'b1, 5'h04, 8'h10);
    rx_ev(1'b1, 1'b0, 8'h11);
    check({irq_er, rx_en}, 8'h00);
    rdc(5'h08, 8'h78, 8'h10);
    rw(1'b1, 5'h04, 8'h50);
    check({7'h0, irq_er}, 8'h01);
    rw(1'b1, 5'h08, 8'h00);
    @(posedge clk);
    cfg.parity_on <= 1'b1;
    rx_ev(1'b0, 1'b1, 8'ha5);
    rdc(5'h08, 8'h78, 8'h08);
    rdc(5'h14, 8'hff, 8'ha5);
    check({7'h0, rx_en}, 8'h00);
    @(posedge clk);
    cfg <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    rw(1'b1, 5'h04, 8'h08);
    check({7'h0, mp_ie}, 8'h01);
    @(posedge clk);
    cfg.sync_mode <= 1'b1;
    idle(1);
    check({7'h0, mp_ie}, 8'h00);
    @(posedge clk);
    cfg <= '0;
    rw(1'b1, 5'h04, 8'h00);
    rw(1'b1, 5'h0c, 8'h0a);
    idle(2);
    check({txd, sck_oe, sck_o}, 8'h02);
    rw(1'b1, 5'h0c, 8'h7f);
    idle(4);
    check({txd, sck_oe, sck_o}, 8'h07);
    rdc(5'h0c, 8'hff, 8'h0f);
    rw(1'b1, 5'h0c, 8'h00);
    rxd_lv <= 1'b0;
    idle(5);
    rdc(5'h0c, 8'hff, 8'h04);
    rxd_lv <= 1'b1;
    sck_lv <= 1'b0;
    idle(5);
    rdc(5'h0c, 8'hff, 8'h01);
    rw(1'b1, 5'h00, 8'h12);
    @(posedge clk);
    be <= 4'he;
    rw(1'b1, 5'h00, 8'h34);
    @(posedge clk);
    be <= 4'hf;
    rdc(5'h00, 8'hff, 8'h12);
    rw(1'b1, 5'h04, 8'he4);
    rw(1'b1, 5'h0c, 8'h8a);
    @(posedge clk);
    stby <= 1'b1;
    repeat (2) @(posedge clk);
    stby <= 1'b0;
    rdc(5'h04, 8'hff, 8'h00);
    rdc(5'h08, 8'hff, 8'h84);
    rdc(5'h00, 8'hff, 8'hff);
    rdc(5'h0c, 8'h8a, 8'h8a);
    rw(1'b1, 5'h04, 8'h30);
    @(posedge clk);
    mstby <= 1'b1;
    repeat (2) @(posedge clk);
    mstby <= 1'b0;
    rdc(5'h04, 8'hff, 8'h00);
    rdc(5'h0c, 8'h8a, 8'h8a);
    summarize();
  end
endmodule
